// [shared/fault_monitor_params.svh]
// Purpose: offsets, field positions, setting codes and timing counts of the drive fault monitor
// Assumes: 32-bit APB, word-aligned registers
// Notes: all timers count ticks of the 1 ms time base derived from mclk
`ifndef FAULT_MONITOR_PARAMS_SVH
`define FAULT_MONITOR_PARAMS_SVH

// ==========================================================
// register byte offsets
`define OFS_FAULT_STATUS 12'h000
`define OFS_FAULT_MASK 12'h004
`define OFS_MODE_CFG 12'h008
`define OFS_ENC_CFG 12'h00c
`define OFS_SPD_CFG 12'h010
`define OFS_COMM_CFG 12'h014
`define OFS_FB_CFG 12'h018
`define OFS_FB_VALUE 12'h01c
`define OFS_SPEED_VALUE 12'h020
`define OFS_BUS_CMD 12'h024
`define OFS_INPUT_FUNC_LO 12'h028
`define OFS_INPUT_FUNC_HI 12'h02c
`define OFS_LIVE_STATE 12'h030

// ==========================================================
// fault status bit positions
`define BIT_ENC_OPEN 0
`define BIT_SPEED_ERR 1
`define BIT_COMM 2
`define BIT_FB_LOSS 3
`define BIT_STO 4
`define BIT_STO_INPUT 5
`define BIT_STOP_COND 6
`define BIT_BUS_EXT 7
`define BIT_INPUT_EXT 8
`define NUM_FAULTS 16

// bus command word bit that raises the bus external fault
`define BUS_CMD_EXT_BIT 2

// ==========================================================
// setting codes
`define FUNC_EXT_FAULT_A 8'h19
`define FUNC_EXT_FAULT_B 8'h44
`define FUNC_SAFE_STOP 8'h3a
`define STOP_METHOD_RAMP 2'h0
`define STOP_METHOD_COAST 2'h1

// ==========================================================
// timing
`define CLK_HZ 25000000
`define TICK_HZ 1000
`define TICK_CYCLES (`CLK_HZ / `TICK_HZ)

`endif

// [shared/fault_monitor_pkg.sv]
// Purpose: types shared by the drive fault monitor
// Assumes: nothing
// Notes: counters and settings widths
package fault_monitor_pkg;
  typedef logic [15:0] time_set_t;
  typedef logic [15:0] level_t;
  typedef logic [7:0] func_code_t;
  typedef enum logic [2:0] {
    apb_idle = 3'b001,
    apb_setup = 3'b010,
    apb_access = 3'b100
  } apb_state_t;
endpackage

// [rtl/pin_sync.sv]
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: input asynchronous to mclk
// Notes: output changes only when stages two and three agree
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
  wire [WIDTH-1:0] next_level = (agree & stage3) | (~agree & level);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
    end else if (clk_en) begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end
endmodule

// [rtl/interval_timer.sv]
// Purpose: counts time base ticks while a condition holds, flags expiry
// Assumes: tick is a one-cycle pulse on mclk
// Notes: a limit of zero expires at the first tick of the condition
`include "fault_monitor_params.svh"
module interval_timer
  import fault_monitor_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic tick,
  input wire logic cond,
  input wire time_set_t limit,
  output logic expired
);
  time_set_t count;
  wire reached = (count >= limit);
  wire next_expired = cond & tick & reached;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= '0;
      expired <= 1'b0;
    end else if (clk_en) begin
      expired <= next_expired;
      // restart whenever the condition drops before expiry
      if (!cond)
        count <= '0;
      else if (tick && !reached)
        count <= count + 16'h0001;
    end
  end
endmodule

// [rtl/drive_fault_monitor.sv]
// Purpose: fault detection for a motor drive, APB register slave
// Assumes: mclk 25 MHz, rst asynchronous active high
// Notes: status bits are sticky, cleared by writing one or by fault_reset
//
// Chosen here: the APB register port and the register offsets.
`include "fault_monitor_params.svh"
module drive_fault_monitor
  import fault_monitor_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic encoder_pulse,
  input wire logic bus_msg_valid,
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic safety_reference,
  input wire logic [7:0] digital_inputs,
  input wire logic fault_reset,
  output logic encoder_open_fault,
  output logic speed_error_fault,
  output logic comm_fault,
  output logic feedback_loss_fault,
  output logic safe_torque_off_fault,
  output logic safe_torque_off_input_fault,
  output logic input_stop_condition,
  output logic bus_external_fault,
  output logic [7:0] input_external_fault,
  output logic irq
);

  // ==========================================================
  // settings registers
  logic [`NUM_FAULTS-1:0] fault_status;
  logic [`NUM_FAULTS-1:0] fault_mask;
  logic [2:0] control_mode;
  logic [1:0] stop_method;
  logic [1:0] ext_fault_sel;
  time_set_t enc_open_time;
  level_t spd_level;
  time_set_t spd_time;
  logic [1:0] spd_action;
  time_set_t comm_time;
  logic [1:0] comm_action;
  level_t fb_level;
  time_set_t fb_time;
  logic [1:0] fb_action;
  level_t fb_value;
  level_t speed_value;
  logic [15:0] bus_cmd;
  func_code_t input_func [8];

  // ==========================================================
  // pin synchronisers
  logic enc_sync;
  logic msg_sync;
  logic [2:0] safety_sync;
  logic [7:0] din_sync;

  pin_sync #(.WIDTH(1)) u_sync_enc (
    .mclk(mclk), .rst(rst), .clk_en(clk_en), .pin(encoder_pulse), .level(enc_sync)
  );
  pin_sync #(.WIDTH(1)) u_sync_msg (
    .mclk(mclk), .rst(rst), .clk_en(clk_en), .pin(bus_msg_valid), .level(msg_sync)
  );
  pin_sync #(.WIDTH(3)) u_sync_safety (
    .mclk(mclk), .rst(rst), .clk_en(clk_en),
    .pin({safety_reference, ~safety_input_b, ~safety_input_a}), .level(safety_sync)
  );
  pin_sync #(.WIDTH(8)) u_sync_din (
    .mclk(mclk), .rst(rst), .clk_en(clk_en), .pin(digital_inputs), .level(din_sync)
  );

  // edge detection on filtered levels, so each pulse or message counts once
  logic enc_prev;
  logic msg_prev;
  wire enc_edge = enc_sync & ~enc_prev;
  wire msg_edge = msg_sync & ~msg_prev;

  // ==========================================================
  // 1 ms time base
  logic [31:0] tick_count;
  logic tick;
  wire tick_wrap = (tick_count == 32'(TICK_CYCLES - 1));
  wire [31:0] next_tick_count = tick_wrap ? 32'h0000_0000 : tick_count + 32'h0000_0001;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_count <= 32'h0000_0000;
      tick <= 1'b0;
      enc_prev <= 1'b0;
      msg_prev <= 1'b0;
    end else if (clk_en) begin
      tick_count <= next_tick_count;
      tick <= tick_wrap;
      enc_prev <= enc_sync;
      msg_prev <= msg_sync;
    end
  end

  // ==========================================================
  // qualifying conditions
  function automatic logic is_ext_func(input func_code_t code);
    return (code == `FUNC_EXT_FAULT_A) || (code == `FUNC_EXT_FAULT_B);
  endfunction

  // control modes 1, 3, 4 use the encoder
  wire encoder_mode = (control_mode == 3'h1) || (control_mode == 3'h3) ||
    (control_mode == 3'h4);
  wire spd_armed = encoder_mode && (spd_action <= 2'h1);
  wire comm_armed = (comm_action <= 2'h2);
  wire fb_armed = (fb_action == 2'h2);
  wire ext_armed = (ext_fault_sel <= 2'h1);

  // a pulse restarts the open-circuit interval
  wire enc_cond = encoder_mode && !enc_edge;
  wire spd_cond = spd_armed && (speed_value > spd_level);
  wire comm_cond = comm_armed && !msg_edge;
  wire fb_cond = fb_armed && (fb_value < fb_level);

  logic enc_expired;
  logic spd_expired;
  logic comm_expired;
  logic fb_expired;

  interval_timer u_tmr_enc (
    .mclk(mclk), .rst(rst), .clk_en(clk_en), .tick(tick),
    .cond(enc_cond), .limit(enc_open_time), .expired(enc_expired)
  );
  interval_timer u_tmr_spd (
    .mclk(mclk), .rst(rst), .clk_en(clk_en), .tick(tick),
    .cond(spd_cond), .limit(spd_time), .expired(spd_expired)
  );
  interval_timer u_tmr_comm (
    .mclk(mclk), .rst(rst), .clk_en(clk_en), .tick(tick),
    .cond(comm_cond), .limit(comm_time), .expired(comm_expired)
  );
  interval_timer u_tmr_fb (
    .mclk(mclk), .rst(rst), .clk_en(clk_en), .tick(tick),
    .cond(fb_cond), .limit(fb_time), .expired(fb_expired)
  );

  // inputs a, b enter inverted: every bit is 0 when connected, so reset raises no fault
  wire sto_event = |safety_sync;

  // terminal n uses setting n
  wire [7:0] safe_stop_sel;
  wire [7:0] ext_event;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_term
      assign safe_stop_sel[gi] = (input_func[gi] == `FUNC_SAFE_STOP);
      assign ext_event[gi] = ext_armed && is_ext_func(input_func[gi]) &&
        din_sync[gi];
    end
  endgenerate

  wire sto_input_event = (stop_method == `STOP_METHOD_COAST) &&
    |(safe_stop_sel & ~din_sync);
  wire stop_cond_event = (stop_method == `STOP_METHOD_RAMP) &&
    |(safe_stop_sel & din_sync);
  wire bus_ext_event = bus_cmd[`BUS_CMD_EXT_BIT];

  wire [`NUM_FAULTS-1:0] fault_events = {
    ext_event, bus_ext_event, stop_cond_event, sto_input_event, sto_event,
    fb_expired, comm_expired, spd_expired, enc_expired
  };

  // ==========================================================
  // apb slave
  apb_state_t apb_state;
  wire apb_access_cyc = psel && penable;
  wire wr_en = apb_access_cyc && pwrite && (apb_state == apb_setup);
  wire addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `OFS_LIVE_STATE);
  wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] w_status = pwdata & wmask;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [31:0] msk);
    return (old & ~msk[15:0]) | (data[15:0] & msk[15:0]);
  endfunction

  wire write_status = wr_en && (paddr == `OFS_FAULT_STATUS);
  logic fault_reset_sync;
  // a new event wins over a write-one clear and over fault reset, which clears all else
  wire [`NUM_FAULTS-1:0] next_fault_status = fault_reset_sync ? fault_events :
    ((fault_status & ~(write_status ? w_status[`NUM_FAULTS-1:0] : 16'h0000)) | fault_events);

  pin_sync #(.WIDTH(1)) u_sync_reset (
    .mclk(mclk), .rst(rst), .clk_en(clk_en), .pin(fault_reset), .level(fault_reset_sync)
  );

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `OFS_FAULT_STATUS: rd_mux = {16'h0000, fault_status};
      `OFS_FAULT_MASK: rd_mux = {16'h0000, fault_mask};
      `OFS_MODE_CFG: rd_mux = {24'h000000, ext_fault_sel, 1'b0, stop_method, control_mode};
      `OFS_ENC_CFG: rd_mux = {16'h0000, enc_open_time};
      `OFS_SPD_CFG: rd_mux = {spd_action, 14'h0000, spd_time};
      `OFS_COMM_CFG: rd_mux = {14'h0000, comm_action, comm_time};
      `OFS_FB_CFG: rd_mux = {14'h0000, fb_action, fb_time};
      `OFS_FB_VALUE: rd_mux = {fb_level, fb_value};
      `OFS_SPEED_VALUE: rd_mux = {spd_level, speed_value};
      `OFS_BUS_CMD: rd_mux = {16'h0000, bus_cmd};
      `OFS_INPUT_FUNC_LO: rd_mux = {input_func[3], input_func[2], input_func[1], input_func[0]};
      `OFS_INPUT_FUNC_HI: rd_mux = {input_func[7], input_func[6], input_func[5], input_func[4]};
      `OFS_LIVE_STATE: rd_mux = {8'h00, din_sync, 4'h0, safety_sync, enc_sync, fault_events[7:0]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // no wait state: setup, then access answered in its first cycle
  apb_state_t next_apb_state;
  always_comb begin
    case (apb_state)
      apb_idle: next_apb_state = (psel && !penable) ? apb_setup : apb_idle;
      apb_setup: next_apb_state = apb_access;
      apb_access: next_apb_state = (psel && !penable) ? apb_setup : apb_idle;
      default: next_apb_state = apb_idle;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      apb_state <= apb_idle;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      apb_state <= next_apb_state;
      pready <= (apb_state == apb_setup) ? 1'b0 : (next_apb_state == apb_setup);
      pslverr <= (next_apb_state == apb_setup) && !addr_ok;
      if (next_apb_state == apb_setup && !pwrite)
        prdata <= rd_mux;
    end
  end

  // ==========================================================
  // register writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fault_status <= 16'h0000;
      fault_mask <= 16'h0000;
      control_mode <= 3'h0;
      stop_method <= 2'h0;
      ext_fault_sel <= 2'h3;
      enc_open_time <= 16'h0000;
      spd_level <= 16'hffff;
      spd_time <= 16'h0000;
      spd_action <= 2'h3;
      comm_time <= 16'h0000;
      comm_action <= 2'h3;
      fb_level <= 16'h0000;
      fb_time <= 16'h0000;
      fb_action <= 2'h0;
      fb_value <= 16'h0000;
      speed_value <= 16'h0000;
      bus_cmd <= 16'h0000;
      for (int i = 0; i < 8; i++)
        input_func[i] <= 8'h00;
    end else if (clk_en) begin
      fault_status <= next_fault_status;
      if (wr_en) begin
        case (paddr)
          `OFS_FAULT_MASK: fault_mask <= merge16(fault_mask, pwdata, wmask);
          `OFS_MODE_CFG: begin
            if (pstrb[0]) begin
              control_mode <= pwdata[2:0];
              stop_method <= pwdata[4:3];
              ext_fault_sel <= pwdata[7:6];
            end
          end
          `OFS_ENC_CFG: enc_open_time <= merge16(enc_open_time, pwdata, wmask);
          `OFS_SPD_CFG: begin
            spd_time <= merge16(spd_time, pwdata, wmask);
            if (pstrb[3])
              spd_action <= pwdata[31:30];
          end
          `OFS_COMM_CFG: begin
            comm_time <= merge16(comm_time, pwdata, wmask);
            if (pstrb[2])
              comm_action <= pwdata[17:16];
          end
          `OFS_FB_CFG: begin
            fb_time <= merge16(fb_time, pwdata, wmask);
            if (pstrb[2])
              fb_action <= pwdata[17:16];
          end
          `OFS_FB_VALUE: begin
            fb_value <= merge16(fb_value, pwdata, wmask);
            fb_level <= merge16(fb_level, {16'h0000, pwdata[31:16]}, {16'h0000, wmask[31:16]});
          end
          `OFS_SPEED_VALUE: begin
            speed_value <= merge16(speed_value, pwdata, wmask);
            spd_level <= merge16(spd_level, {16'h0000, pwdata[31:16]}, {16'h0000, wmask[31:16]});
          end
          `OFS_BUS_CMD: bus_cmd <= merge16(bus_cmd, pwdata, wmask);
          `OFS_INPUT_FUNC_LO: begin
            for (int i = 0; i < 4; i++)
              if (pstrb[i])
                input_func[i] <= pwdata[8*i +: 8];
          end
          `OFS_INPUT_FUNC_HI: begin
            for (int i = 0; i < 4; i++)
              if (pstrb[i])
                input_func[i+4] <= pwdata[8*i +: 8];
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // fault outputs, registered
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      encoder_open_fault <= 1'b0;
      speed_error_fault <= 1'b0;
      comm_fault <= 1'b0;
      feedback_loss_fault <= 1'b0;
      safe_torque_off_fault <= 1'b0;
      safe_torque_off_input_fault <= 1'b0;
      input_stop_condition <= 1'b0;
      bus_external_fault <= 1'b0;
      input_external_fault <= 8'h00;
      irq <= 1'b0;
    end else if (clk_en) begin
      encoder_open_fault <= next_fault_status[`BIT_ENC_OPEN];
      speed_error_fault <= next_fault_status[`BIT_SPEED_ERR];
      comm_fault <= next_fault_status[`BIT_COMM];
      feedback_loss_fault <= next_fault_status[`BIT_FB_LOSS];
      safe_torque_off_fault <= next_fault_status[`BIT_STO];
      safe_torque_off_input_fault <= next_fault_status[`BIT_STO_INPUT];
      input_stop_condition <= next_fault_status[`BIT_STOP_COND];
      bus_external_fault <= next_fault_status[`BIT_BUS_EXT];
      input_external_fault <= next_fault_status[`BIT_INPUT_EXT +: 8];
      irq <= |(next_fault_status & fault_mask);
    end
  end

endmodule

// [sim/fault_partner.sv]
// Purpose: far-side pins: encoder, serial host, safety loop, digital inputs
// Assumes: bench commands change just after mclk edges
// Notes: a pulse or message every 8 mclk, well inside any nonzero detect time
module fault_partner (
  input wire logic mclk,
  input wire logic pulse_on,
  input wire logic msg_on,
  input wire logic [2:0] safe_cut,
  input wire logic [7:0] di_cmd,
  output logic encoder_pulse,
  output logic bus_msg_valid,
  output logic safety_input_a,
  output logic safety_input_b,
  output logic safety_reference,
  output logic [7:0] digital_inputs
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] phase = 3'h0;
  always @(posedge mclk) begin
    phase <= phase + 3'h1;
  end
  assign encoder_pulse = pulse_on & phase[2];
  assign bus_msg_valid = msg_on & phase[2];
  // a cut opens the loop: inputs fall, reference floats high
  assign safety_input_a = ~safe_cut[0];
  assign safety_input_b = ~safe_cut[1];
  assign safety_reference = safe_cut[2];
  assign digital_inputs = di_cmd;
endmodule

// [sim/drive_fault_monitor_assertions.sv]
// Purpose: port checks of the drive fault monitor
// Assumes: clk_en held high
// Notes: pins pass a sync filter, so pin-caused checks allow slack
module drive_fault_monitor_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic safety_input_a,
  input wire logic [7:0] digital_inputs,
  input wire logic fault_reset,
  input wire logic encoder_open_fault,
  input wire logic speed_error_fault,
  input wire logic comm_fault,
  input wire logic feedback_loss_fault,
  input wire logic safe_torque_off_fault,
  input wire logic safe_torque_off_input_fault,
  input wire logic input_stop_condition,
  input wire logic bus_external_fault,
  input wire logic [7:0] input_external_fault,
  input wire logic irq
);
  wire [15:0] outs = {input_external_fault, bus_external_fault, input_stop_condition,
    safe_torque_off_input_fault, safe_torque_off_fault, feedback_loss_fault, comm_fault,
    speed_error_fault, encoder_open_fault};
  logic [3:0] clr_cnt;
  logic [7:0] di_hist;
  // ==========================================
  // helpers
  // clears arrive late through the reset sync, so keep a window open
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clr_cnt <= 4'h0;
      di_hist <= 8'h0;
    end else begin
      clr_cnt <= (fault_reset || (psel && pwrite)) ? 4'hf : clr_cnt - {3'h0, |clr_cnt};
      di_hist <= {di_hist[6:0], |digital_inputs};
    end
  end
  // ==========================================
  // properties
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_answer;
    psel && !penable |=> pready && penable;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  property p_slverr;
    pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 12'h030);
  endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr wrong");
  property p_sto;
    (!safety_input_a) [*8] |-> ##[0:4] safe_torque_off_fault;
  endproperty
  a_sto: assert property (p_sto) else $error("no safe torque off fault");
  property p_bus_ext;
    pready && pwrite && paddr == 12'h024 && pwdata[2] |-> ##[1:4] bus_external_fault;
  endproperty
  a_bus_ext: assert property (p_bus_ext) else $error("no bus external fault");
  property p_term;
    (outs[15:8] & ~$past(outs[15:8])) != 8'h0 |-> |di_hist;
  endproperty
  a_term: assert property (p_term) else $error("terminal fault with no input");
  property p_held;
    clr_cnt == 4'h0 |-> ($past(outs) & ~outs) == 16'h0;
  endproperty
  a_held: assert property (p_held) else $error("fault dropped unasked");
  property p_irq;
    irq |-> outs != 16'h0;
  endproperty
  a_irq: assert property (p_irq) else $error("irq with no fault");
  c_sto: cover property ($rose(safe_torque_off_fault));
  c_term: cover property ($rose(|input_external_fault));
  c_err: cover property (pready && pslverr);
endmodule

bind drive_fault_monitor drive_fault_monitor_assertions u_drive_fault_monitor_assertions (.*);

// [sim/tb_drive_fault_monitor.sv]
// Purpose: self-checking bench of the drive fault monitor
// Assumes: time base shortened to TK cycles per tick
// Notes: each fault is read from status and from its pin
`include "fault_monitor_params.svh"
module tb_drive_fault_monitor import fault_monitor_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 10;
  logic mclk = 1'b0, rst = 1'b1, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic fault_reset = 1'b0, pulse_on = 1'b1, msg_on = 1'b1, e, v;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] safe_cut = 3'h0;
  logic [7:0] di_cmd = 8'h0, digital_inputs, input_external_fault;
  logic pready, pslverr, encoder_pulse, bus_msg_valid, safety_input_a, safety_input_b;
  logic safety_reference, encoder_open_fault, speed_error_fault, comm_fault, irq;
  logic feedback_loss_fault, safe_torque_off_fault, safe_torque_off_input_fault;
  logic input_stop_condition, bus_external_fault;
  int mismatches = 0, cmp_count = 0;
  func_code_t pick [4] = '{`FUNC_EXT_FAULT_A, `FUNC_EXT_FAULT_B, `FUNC_SAFE_STOP, 8'h01};
  wire [15:0] outs = {input_external_fault, bus_external_fault, input_stop_condition,
    safe_torque_off_input_fault, safe_torque_off_fault, feedback_loss_fault, comm_fault,
    speed_error_fault, encoder_open_fault};
  drive_fault_monitor #(.TICK_CYCLES(TK)) u_drive_fault_monitor (.*);
  fault_partner u_fault_partner (.*);
  initial forever #20 mclk = ~mclk;
  // ==========================================
  // tasks
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] got);
    cmp_count++;
    if (got !== x) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, x, got);
    end
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      cmp("pready", 1, 0);
      finish_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic clr();
    wr(`OFS_FAULT_STATUS, 32'hffff);
  endtask
  task automatic stat(input string nm, input int b, input logic x);
    apb(1'b0, `OFS_FAULT_STATUS, 32'h0);
    cmp(nm, x, r[b]);
    cmp({nm, " pin"}, x, outs[b]);
  endtask
  function automatic logic term_exp(func_code_t f, logic [1:0] s, logic d);
    return d && s <= 2'h1 && (f == `FUNC_EXT_FAULT_A || f == `FUNC_EXT_FAULT_B);
  endfunction
  // ==========================================
  // sequence
  initial begin
    int t;
    logic [1:0] sel;
    logic [63:0] fw;
    void'($urandom(59123));
    hold(16);
    rst <= 1'b0;
    apb(1'b0, 12'h034, 32'h0);
    cmp("unmapped err", 1, e);
    cmp("unmapped data", 0, r);
    apb(1'b1, 12'h002, 32'hffffffff);
    cmp("unaligned err", 1, e);
    pstrb <= 4'he;
    wr(`OFS_MODE_CFG, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, `OFS_MODE_CFG, 32'h0);
    cmp("ext sel reset", 3, r[7:6]);
    $display("test regs done");
    for (int k = 0; k < 3; k++) begin
      safe_cut <= 3'(1 << k);
      hold(12);
      safe_cut <= 3'h0;
      hold(12);
      stat("sto", `BIT_STO, 1'b1);
      clr();
      stat("sto clear", `BIT_STO, 1'b0);
    end
    safe_cut <= 3'h4;
    hold(12);
    safe_cut <= 3'h0;
    fault_reset <= 1'b1;
    hold(12);
    fault_reset <= 1'b0;
    hold(8);
    stat("fault reset", `BIT_STO, 1'b0);
    $display("test sto done");
    wr(`OFS_FAULT_MASK, 32'h0);
    wr(`OFS_BUS_CMD, 32'h4);
    hold(2);
    stat("bus ext", `BIT_BUS_EXT, 1'b1);
    cmp("irq masked", 0, irq);
    wr(`OFS_FAULT_MASK, 32'h80);
    hold(2);
    cmp("irq", 1, irq);
    wr(`OFS_BUS_CMD, 32'h0);
    clr();
    stat("bus ext off", `BIT_BUS_EXT, 1'b0);
    cmp("irq off", 0, irq);
    $display("test bus done");
    for (int i = 0; i < 12; i++) begin
      t = $urandom_range(7);
      sel = 2'($urandom_range(3));
      v = 1'($urandom_range(1));
      fw = 64'(pick[i % 4]) << (8 * t);
      wr(`OFS_INPUT_FUNC_LO, fw[31:0]);
      wr(`OFS_INPUT_FUNC_HI, fw[63:32]);
      wr(`OFS_MODE_CFG, {24'h0, sel, 6'h0});
      di_cmd <= 8'(v) << t;
      hold(10);
      stat("term ext", `BIT_INPUT_EXT + t, term_exp(pick[i % 4], sel, v));
      di_cmd <= 8'h0;
      hold(10);
      clr();
    end
    $display("test terminals done");
    wr(`OFS_INPUT_FUNC_HI, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(`OFS_MODE_CFG, {28'h0, m[1], 3'h0});
      di_cmd <= {7'h0, m[0]};
      hold(10);
      wr(`OFS_INPUT_FUNC_LO, {24'h0, `FUNC_SAFE_STOP});
      hold(2);
      stat("stop cond", `BIT_STOP_COND, m == 1);
      stat("sto input", `BIT_STO_INPUT, m == 2);
      wr(`OFS_INPUT_FUNC_LO, 32'h0);
      clr();
    end
    $display("test stop done");
    wr(`OFS_ENC_CFG, 32'h3);
    for (int c = 0; c < 5; c++) begin
      wr(`OFS_MODE_CFG, 32'(c));
      pulse_on <= 1'b0;
      hold(TK);
      stat("enc early", `BIT_ENC_OPEN, 1'b0);
      hold(5 * TK);
      stat("enc open", `BIT_ENC_OPEN, c == 1 || c >= 3);
      pulse_on <= 1'b1;
      hold(20);
      clr();
    end
    for (int a = 0; a < 4; a++) begin
      wr(`OFS_COMM_CFG, {14'h0, 2'(a), 16'h3});
      msg_on <= 1'b0;
      hold(6 * TK);
      stat("comm", `BIT_COMM, a <= 2);
      msg_on <= 1'b1;
      hold(20);
      clr();
    end
    for (int a = 0; a < 5; a++) begin
      wr(`OFS_FB_VALUE, {16'h0064, a == 4 ? 16'h0064 : 16'($urandom_range(99))});
      wr(`OFS_FB_CFG, {14'h0, a == 4 ? 2'h2 : 2'(a), 16'h3});
      hold(6 * TK);
      stat("fb loss", `BIT_FB_LOSS, a == 2);
      wr(`OFS_FB_CFG, 32'h3);
      clr();
    end
    wr(`OFS_MODE_CFG, 32'h1);
    for (int a = 0; a < 5; a++) begin
      wr(`OFS_SPEED_VALUE, {16'h00c8, a == 4 ? 16'h00c8 : 16'h00c9 + 16'($urandom_range(500))});
      wr(`OFS_SPD_CFG, {a == 4 ? 2'h0 : 2'(a), 14'h0, 16'h3});
      hold(6 * TK);
      stat("speed dev", `BIT_SPEED_ERR, a < 2);
      wr(`OFS_SPD_CFG, 32'hc0000003);
      clr();
    end
    $display("test timers done");
    finish_test();
  end
endmodule
